/* File: hdl/kms_params.svh */
/*
  offsets, field positions, reset values and timing counts of the key matrix scanner.
  assumes a 100 MHz core clock and full 32-bit byte addresses on the register port.
*/
`ifndef KMS_PARAMS_SVH
`define KMS_PARAMS_SVH

// ================================================================
// register byte addresses
`define KMS_ADDR_SCAN_SETUP   32'h808f0000
`define KMS_ADDR_PROBE_KEY    32'h808f0004
`define KMS_ADDR_KEY_CAPTURE  32'h808f0008
`define KMS_ADDR_POWER_CTRL   32'h808f000c

// ================================================================
// scan_setup fields
`define KMS_SETUP_WIDTH       24
`define KMS_SETUP_RESET       24'h000000
`define KMS_F_DIVIDER_LSB     0
`define KMS_F_DIVIDER_MSB     9
`define KMS_F_SPARE_LSB       10
`define KMS_F_SPARE_MSB       11
`define KMS_F_ROW_TEST        12
`define KMS_F_BACK_DRIVE      13
`define KMS_F_PROBE_EN        14
`define KMS_F_TRIPLE_DIS      15
`define KMS_F_DEBOUNCE_LSB    16
`define KMS_F_DEBOUNCE_MSB    23

// ================================================================
// key_capture fields
`define KMS_F_KEY1_LSB        0
`define KMS_F_KEY2_LSB        6
`define KMS_F_COUNT_LSB       12
`define KMS_F_PRESENT         14
`define KMS_F_PENDING         15

// ================================================================
// debounce and stepping
`define KMS_DEBOUNCE_TERMINAL 8'hff
`define KMS_ROW_TEST_STRIDE   6'h08
`define KMS_BACK_DRIVE_COLS   3'h2
`define KMS_TRIPLE_ROW        3'h0
`define KMS_TRIPLE_COL_A      2
`define KMS_TRIPLE_COL_B      4
`define KMS_TRIPLE_COL_C      7

// ================================================================
// timing
`define KMS_CLK_HZ            100000000
`define KMS_TICK_HZ           1000000
`define KMS_TICK_CYCLES       (`KMS_CLK_HZ / `KMS_TICK_HZ)

`endif

/* File: hdl/kms_pkg.sv */
/*
  types shared by the key matrix scanner.
  assumes nothing beyond a SystemVerilog compiler.
*/
package kms_pkg;

  // ================================================================
  // decoded result of one full array scan
  typedef struct packed {
    logic [1:0] count;
    logic [5:0] key2;
    logic [5:0] key1;
  } kms_keys_t;

  // ================================================================
  // matrix pin group
  typedef struct packed {
    logic [7:0] row_out;
    logic [7:0] row_oe;
    logic [7:0] col_out;
    logic [7:0] col_oe;
  } kms_pins_t;

  typedef enum logic [1:0] {
    KMS_MODE_SCAN,
    KMS_MODE_PROBE
  } kms_mode_t;

endpackage

/* File: hdl/kms_scanner.sv */
/*
  key matrix scanner: row drive, column sampling, two-key decode, debounce,
  latched key interrupt, wake detect, three-key reset request and test modes.
  assumes pulled-up column pins from outside the clock domain and a register
  master on the same clock that reads and writes whole words only.
*/
`include "kms_params.svh"

module kms_scanner
  import kms_pkg::*;
#(
  parameter int TICK_CYCLES = `KMS_TICK_CYCLES
)(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [7:0]  col_in,
  output kms_pins_t        pins,
  output logic             key_irq,
  output logic             wake_irq,
  output logic             reset_keys_detected
);

  // ================================================================
  // registers
  logic [23:0] scan_setup;
  logic [5:0]  diagnostic_key_select;
  logic        low_power_mode;
  logic [9:0]  step_divider_load;
  logic        row_test_mode;
  logic        back_drive;
  logic        manual_probe_enable;
  logic        triple_reset_disable;
  logic [7:0]  debounce_start_value;

  assign step_divider_load    = scan_setup[`KMS_F_DIVIDER_MSB:`KMS_F_DIVIDER_LSB];
  assign row_test_mode        = scan_setup[`KMS_F_ROW_TEST];
  assign back_drive           = scan_setup[`KMS_F_BACK_DRIVE];
  assign manual_probe_enable  = scan_setup[`KMS_F_PROBE_EN];
  assign triple_reset_disable = scan_setup[`KMS_F_TRIPLE_DIS];
  assign debounce_start_value = scan_setup[`KMS_F_DEBOUNCE_MSB:`KMS_F_DEBOUNCE_LSB];

  kms_mode_t mode;
  assign mode = manual_probe_enable ? KMS_MODE_PROBE : KMS_MODE_SCAN;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      scan_setup <= `KMS_SETUP_RESET;
    else if (wr && addr == `KMS_ADDR_SCAN_SETUP)
      scan_setup <= wdata[23:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      diagnostic_key_select <= 6'h00;
      low_power_mode        <= 1'b0;
    end
    else if (wr && addr == `KMS_ADDR_PROBE_KEY)
      diagnostic_key_select <= wdata[5:0];
    else if (wr && addr == `KMS_ADDR_POWER_CTRL)
      low_power_mode <= wdata[0];
  end

  // ================================================================
  // column synchroniser
  logic [7:0] col_meta;
  logic [7:0] col_sync;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      col_meta <= 8'hff;
      col_sync <= 8'hff;
    end
    else
    begin
      col_meta <= col_in;
      col_sync <= col_meta;
    end
  end

  // ================================================================
  // 1 MHz enable and prescaler
  logic [7:0] tick_cnt;
  logic       tick;
  logic [9:0] pre_cnt;
  logic       step;

  assign tick = (tick_cnt == 8'(TICK_CYCLES - 1));

  always_ff @(posedge mclk)
  begin
    if (!nrst || tick)
      tick_cnt <= 8'h00;
    else
      tick_cnt <= tick_cnt + 8'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      pre_cnt <= 10'h000;
    else if (tick)
      pre_cnt <= (pre_cnt == 10'h000) ? step_divider_load : pre_cnt - 10'h001;
  end

  assign step = tick && (pre_cnt == 10'h000) && (mode == KMS_MODE_SCAN);

  // ================================================================
  // row/column counter: 64 steps per scan, 8 in row test mode
  logic [5:0] row_column_counter;
  logic [2:0] cur_row;
  logic [2:0] cur_col;
  logic       latch_now;
  logic       scan_end;

  assign cur_row   = row_column_counter[5:3];
  assign cur_col   = row_column_counter[2:0];
  assign latch_now = (cur_col == 3'h7) || row_test_mode;
  // scan closes after the last step of row 7
  assign scan_end  = step && (cur_row == 3'h7) && latch_now;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      row_column_counter <= 6'h00;
    else if (step)
    begin
      // stride of 8 checks column 0 only; column bits cleared so a
      // mid-row entry into the mode still lands on column 0
      if (row_test_mode)
        row_column_counter <= {cur_row, 3'h0} + `KMS_ROW_TEST_STRIDE;
      else
        row_column_counter <= row_column_counter + 6'h01;
    end
  end

  // ================================================================
  // column capture at row end; decoded during the next row (pipelined,
  // so each scan opens with row 7's data)
  logic [7:0] row_data;
  logic       triple_seen;

  // sample columns at the end of the row
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      row_data <= 8'hff;
    else if (step && latch_now)
      row_data <= col_sync;
  end

  // row 0 columns 2, 4, 7 low
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      triple_seen <= 1'b0;
    else if (step && latch_now && cur_row == `KMS_TRIPLE_ROW)
      triple_seen <= !col_sync[`KMS_TRIPLE_COL_A] && !col_sync[`KMS_TRIPLE_COL_B]
                     && !col_sync[`KMS_TRIPLE_COL_C];
  end

  // level while held; disable gates it
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      reset_keys_detected <= 1'b0;
    else
      reset_keys_detected <= triple_seen && !triple_reset_disable;
  end

  // ================================================================
  // decode of the first two keys in a scan
  kms_keys_t acc;
  kms_keys_t next_acc;
  logic [2:0] eval_row;
  logic       hit;
  logic [5:0] eval_addr;

  assign eval_row  = cur_row - 3'h1;
  assign eval_addr = {eval_row, cur_col};
  assign hit       = !row_data[cur_col];

  // keep only the first two hits in decode order: row 7, then rows 0 to 6
  always_comb
  begin
    next_acc = acc;
    if (hit)
    begin
      if (acc.count == 2'h0)
      begin
        next_acc.key1  = eval_addr;
        next_acc.count = 2'h1;
      end
      else if (acc.count == 2'h1)
      begin
        next_acc.key2  = eval_addr;
        next_acc.count = 2'h2;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst || scan_end)
      acc <= '0;
    else if (step)
      acc <= next_acc;
  end

  // ================================================================
  // debounce
  kms_keys_t  last_scan;
  logic [7:0] debounce_cnt;
  logic [7:0] next_debounce_cnt;
  logic       differ;
  logic       fire;

  // any change of count or either key
  assign differ = (next_acc != last_scan);

  always_comb
  begin
    next_debounce_cnt = debounce_cnt;
    if (differ)
      next_debounce_cnt = debounce_start_value;
    else if (debounce_cnt != `KMS_DEBOUNCE_TERMINAL)
      next_debounce_cnt = debounce_cnt + 8'h01;
  end

  // fire only on entering terminal count
  assign fire = scan_end && (next_debounce_cnt == `KMS_DEBOUNCE_TERMINAL)
                && (debounce_cnt != `KMS_DEBOUNCE_TERMINAL);

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      debounce_cnt <= 8'h00;
      last_scan    <= '0;
    end
    else if (scan_end)
    begin
      // reload on change, count on match
      debounce_cnt <= next_debounce_cnt;
      last_scan    <= next_acc;
    end
  end

  // ================================================================
  // capture and interrupt
  kms_keys_t held;
  logic      pending;
  logic      key_present;
  logic      cap_read;

  assign cap_read = rd && addr == `KMS_ADDR_KEY_CAPTURE;

  // newest settled set replaces the held one
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      held <= '0;
    else if (fire)
      held <= next_acc;
  end

  // set wins over the read clear
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      pending <= 1'b0;
    else if (fire)
      pending <= 1'b1;
    else if (cap_read)
      pending <= 1'b0;
  end

  assign key_irq = pending;

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      key_present <= 1'b0;
    else if (mode == KMS_MODE_PROBE)
      key_present <= !col_sync[diagnostic_key_select[2:0]];
  end

  // ================================================================
  // matrix drive
  logic back_active;

  assign back_active = back_drive && (cur_col < `KMS_BACK_DRIVE_COLS);

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      pins <= '0;
    else if (mode == KMS_MODE_PROBE)
    begin
      pins.row_out <= 8'h00;
      pins.row_oe  <= 8'h01 << diagnostic_key_select[5:3];
      pins.col_out <= 8'h00;
      pins.col_oe  <= 8'h00;
    end
    else if (low_power_mode)
    begin
      // idle rows low so any press pulls a column; columns stay inputs
      pins.row_out <= 8'h00;
      pins.row_oe  <= 8'hff;
      pins.col_out <= 8'h00;
      pins.col_oe  <= 8'h00;
    end
    else if (back_active)
    begin
      pins.row_out <= 8'hff;
      pins.row_oe  <= 8'hff;
      pins.col_out <= 8'hff;
      pins.col_oe  <= 8'hff;
    end
    else
    begin
      // one row low at a time
      pins.row_out <= 8'h00;
      pins.row_oe  <= 8'h01 << cur_row;
      pins.col_out <= 8'h00;
      pins.col_oe  <= 8'h00;
    end
  end

  // ================================================================
  // wake detect: raw pins on purpose, must work with clocks stopped
  // and of columns, unclocked
  assign wake_irq = low_power_mode && !(&col_in);

  // ================================================================
  // read port: data one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      rdata <= 32'h00000000;
    else if (rd)
    begin
      case (addr)
        `KMS_ADDR_SCAN_SETUP:  rdata <= {8'h00, scan_setup};
        `KMS_ADDR_PROBE_KEY:   rdata <= {26'h0000000, diagnostic_key_select};
        `KMS_ADDR_KEY_CAPTURE: rdata <= {16'h0000, pending, key_present, held.count,
                                         held.key2, held.key1};
        `KMS_ADDR_POWER_CTRL:  rdata <= {31'h00000000, low_power_mode};
        default:               rdata <= 32'h00000000;
      endcase
    end
  end

endmodule

/* File: dv/kms_key_matrix.sv */
/*
  passive model of an 8x8 matrix of normally open key switches.
  assumes the scanner pads of kms_pins_t; columns carry pull-ups.
*/
module kms_key_matrix
  import kms_pkg::*;
(
  input  wire kms_pins_t   pins,
  input  wire logic [63:0] keys,
  output logic      [7:0]  col_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // contacts
  always_comb
  begin
    for (int c = 0; c < 8; c++)
    begin
      col_in[c] = 1'b1;
      for (int r = 0; r < 8; r++)
        if (keys[r * 8 + c] && pins.row_oe[r] && !pins.row_out[r])
          col_in[c] = 1'b0;
      // a driving pad wins over the pull-up
      if (pins.col_oe[c])
        col_in[c] = pins.col_out[c];
    end
  end
endmodule

/* File: dv/kms_scanner_chk.sv */
/*
  port assertions for kms_scanner, bound to each instance.
  assumes whole-word register accesses on mclk.
*/
`include "kms_params.svh"
module kms_scanner_chk
  import kms_pkg::*;
#(
  parameter int TICK_CYCLES = 100
)(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [7:0]  col_in,
  input wire kms_pins_t   pins,
  input wire logic        key_irq,
  input wire logic        wake_irq,
  input wire logic        reset_keys_detected
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // register mirrors
  logic [23:0] setup_m;
  logic [5:0]  sel_m;
  logic        lp;
  int          dis_cnt;
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      setup_m <= 24'h0;
      sel_m   <= 6'h0;
      lp      <= 1'b0;
    end
    else if (wr)
    begin
      if (addr == `KMS_ADDR_SCAN_SETUP)
        setup_m <= wdata[23:0];
      if (addr == `KMS_ADDR_PROBE_KEY)
        sel_m <= wdata[5:0];
      if (addr == `KMS_ADDR_POWER_CTRL)
        lp <= wdata[0];
    end
  end
  // request may lag the disable bit, so count two scans first
  always_ff @(posedge mclk)
  begin
    if (!nrst || wr || !setup_m[15])
      dis_cnt <= 0;
    else if (dis_cnt < 1000000)
      dis_cnt <= dis_cnt + 1;
  end
  // ==========
  // properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  sequence cap_rd;
    rd && addr == `KMS_ADDR_KEY_CAPTURE;
  endsequence
  sequence irq_kept;
    key_irq && !(rd && addr == `KMS_ADDR_KEY_CAPTURE);
  endsequence
  irq_hold_a: assert property (irq_kept |=> key_irq)
    else $error("key irq dropped without a capture read");
  pend_bit_a: assert property (cap_rd |=> rdata[15] == $past(key_irq) && rdata[31:16] == 16'h0)
    else $error("capture pending bit wrong");
  setup_rb_a: assert property (rd && addr == `KMS_ADDR_SCAN_SETUP |=> rdata == {8'h0, setup_m})
    else $error("setup read back wrong");
  sel_rb_a: assert property (rd && addr == `KMS_ADDR_PROBE_KEY |=> rdata == {26'h0, sel_m})
    else $error("probe select read back wrong");
  unmap_rd_a: assert property (rd && !(addr inside {`KMS_ADDR_SCAN_SETUP, `KMS_ADDR_PROBE_KEY,
    `KMS_ADDR_KEY_CAPTURE, `KMS_ADDR_POWER_CTRL}) |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  wake_lvl_a: assert property (wake_irq == (lp && !(&col_in)))
    else $error("wake output wrong");
  one_row_a: assert property (!lp && !$past(lp, 2) |-> $onehot0(pins.row_oe & ~pins.row_out))
    else $error("more than one row low");
  no_bdrv_a: assert property (!setup_m[13] && !$past(setup_m[13], 2)
    |-> !(|(pins.col_oe & pins.col_out)) && !(|(pins.row_oe & pins.row_out)))
    else $error("pins driven high without back drive");
  rst_off_a: assert property (dis_cnt > 128 * (int'(setup_m[9:0]) + 1) * TICK_CYCLES
    |-> !reset_keys_detected)
    else $error("reset request while disabled");
endmodule
bind kms_scanner kms_scanner_chk #(
  .TICK_CYCLES(TICK_CYCLES)
) u_chk (
  .mclk                (mclk),
  .nrst                (nrst),
  .addr                (addr),
  .wdata               (wdata),
  .wr                  (wr),
  .rd                  (rd),
  .rdata               (rdata),
  .col_in              (col_in),
  .pins                (pins),
  .key_irq             (key_irq),
  .wake_irq            (wake_irq),
  .reset_keys_detected (reset_keys_detected)
);

/* File: dv/testbench.sv */
/*
  self-checking bench: scanner, key matrix model and checker.
  assumes short tick and divider counts, so one scan is 768 cycles.
*/
`include "kms_params.svh"
module testbench
  import kms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  localparam int SCAN = 64 * 3 * TICK;
  localparam logic [31:0] A_SET = `KMS_ADDR_SCAN_SETUP;
  localparam logic [31:0] A_DIA = `KMS_ADDR_PROBE_KEY;
  localparam logic [31:0] A_CAP = `KMS_ADDR_KEY_CAPTURE;
  localparam logic [31:0] A_PWR = `KMS_ADDR_POWER_CTRL;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [7:0]  col_in;
  kms_pins_t   pins;
  logic        key_irq;
  logic        wake_irq;
  logic        reset_keys_detected;
  logic [63:0] keys = 64'h0;
  logic [31:0] lfsr = 32'he5b4;
  logic [31:0] rv;
  logic [5:0]  k1;
  logic [5:0]  k2;
  int          fails = 0;
  int          checks = 0;
  int          n;
  always #5 mclk = ~mclk;
  kms_scanner #(
    .TICK_CYCLES(TICK)
  ) u_dut (
    .mclk                (mclk),
    .nrst                (nrst),
    .addr                (addr),
    .wdata               (wdata),
    .wr                  (wr),
    .rd                  (rd),
    .rdata               (rdata),
    .col_in              (col_in),
    .pins                (pins),
    .key_irq             (key_irq),
    .wake_irq            (wake_irq),
    .reset_keys_detected (reset_keys_detected)
  );
  kms_key_matrix u_keys (
    .pins   (pins),
    .keys   (keys),
    .col_in (col_in)
  );
  // ==========
  // tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] e);
    checks++;
    if (seen !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, e, seen);
    end
  endtask
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
    rd_reg(a, rv);
    check(what, rv & m, e);
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  task automatic press(input logic [63:0] k);
    @(posedge mclk);
    keys <= k;
  endtask
  task automatic wait_irq(output int t);
    t = 0;
    while (key_irq !== 1'b1 && t < 8 * SCAN)
    begin
      step(1);
      t++;
    end
    check("irq", 32'(key_irq), 1);
  endtask
  // first two pressed keys in address order
  function automatic logic [13:0] exp_cap(input logic [63:0] k);
    int q[$];
    for (int a = 0; a < 64; a++)
      if (k[a])
        q.push_back(a);
    if (q.size() == 0)
      return 14'h0;
    if (q.size() == 1)
      return {2'd1, 6'h0, 6'(q[0])};
    return {2'd2, 6'(q[1]), 6'(q[0])};
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (100 * SCAN) @(posedge mclk);
    fails++;
    report_and_stop();
  end
  // ==========
  // sequence
  initial
  begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    rd_chk(A_SET, '1, 32'h0, "setup");
    rd_chk(A_DIA, '1, 32'h0, "probe select");
    rd_chk(A_PWR + 32'h4, '1, 32'h0, "unmapped");
    // divider 2, never 0 or 1
    wr_reg(A_SET, 32'hfffc0c02);
    rd_chk(A_SET, '1, 32'h00fc0c02, "setup rb");
    press((64'h1 << 3) | (64'h1 << 27) | (64'h1 << 42));
    wait_irq(n);
    check("settle", 32'(n > 11 * SCAN / 4 && n < 6 * SCAN), 1);
    rd_chk(A_CAP, 32'hbfff, {18'h2, exp_cap(keys)}, "capture");
    check("irq clear", 32'(key_irq), 0);
    press(64'h0);
    wait_irq(n);
    rd_chk(A_CAP, 32'h3fff, 32'h0, "released");
    for (int i = 0; i < 3; i++)
    begin
      lfsr = lfsr_next(lfsr);
      k1 = 6'(lfsr % 56);
      k2 = 6'((lfsr >> 8) % 56);
      if (k2 == k1)
        k2 = k1 ^ 6'h1;
      press(64'h1 << k1);
      wait_irq(n);
      press(64'h1 << k2);
      step(6 * SCAN);
      rd_chk(A_CAP, 32'hbfff, {18'h2, exp_cap(keys)}, "newest");
    end
    press(64'h94);
    step(2 * SCAN);
    check("reset req", 32'(reset_keys_detected), 1);
    wr_reg(A_SET, 32'h00fc8002);
    step(2 * SCAN);
    check("reset off", 32'(reset_keys_detected), 0);
    wr_reg(A_SET, 32'h00fc0002);
    step(2 * SCAN);
    check("reset back", 32'(reset_keys_detected), 1);
    wr_reg(A_SET, 32'h00ff0002);
    rd_reg(A_CAP, rv);
    press(64'h200);
    step(6 * SCAN);
    check("no irq", 32'(key_irq), 0);
    wr_reg(A_SET, 32'h00fc1002);
    rd_reg(A_CAP, rv);
    press(64'h90000);
    step(6 * SCAN);
    rd_chk(A_CAP, 32'hbfff, {18'h2, exp_cap(keys & 64'h0101010101010101)}, "row test");
    wr_reg(A_SET, 32'h00fc2002);
    n = 0;
    while (pins.row_oe !== 8'hff && n < SCAN)
    begin
      step(1);
      n++;
    end
    check("back drive", 32'(pins.col_oe & pins.col_out), 32'hff);
    press(64'h1 << 21);
    wr_reg(A_SET, 32'h00fc4002);
    wr_reg(A_DIA, 32'h15);
    step(8);
    rd_chk(A_CAP, 32'h4000, 32'h4000, "probe hit");
    wr_reg(A_DIA, 32'h16);
    step(8);
    rd_chk(A_CAP, 32'h4000, 32'h0, "probe miss");
    wr_reg(A_SET, 32'h00fc0002);
    rd_reg(A_CAP, rv);
    wr_reg(A_PWR, 32'h1);
    step(3);
    check("wake", 32'(wake_irq), 1);
    press(64'h0);
    step(1);
    check("wake idle", 32'(wake_irq), 0);
    wr_reg(A_PWR, 32'h0);
    report_and_stop();
  end
endmodule
